// ===== dfemr_regs.vh
// Purpose: offsets, field positions and reset values of the equalizer/eye-monitor bank
// Assumes: 8-bit register port, one register per offset
// Notes:   definitions only
`ifndef DFEMR_REGS_VH
`define DFEMR_REGS_VH

`define DFEMR_A_EQ_DIS      8'h1e
`define DFEMR_A_TAP54       8'h20
`define DFEMR_A_TAP32       8'h21
`define DFEMR_A_MON_OVR     8'h22
`define DFEMR_A_OPEN_OVR    8'h23
`define DFEMR_A_START       8'h24
`define DFEMR_A_CNT_HI      8'h25
`define DFEMR_A_CNT_LO      8'h26
`define DFEMR_A_HOPEN       8'h27
`define DFEMR_A_VOPEN       8'h28
`define DFEMR_A_VRANGE      8'h29
`define DFEMR_A_TIMER       8'h2a
`define DFEMR_A_MINHIT      8'h2b
`define DFEMR_A_MERIT       8'h2c

`define DFEMR_RST_ZERO      8'h00
`define DFEMR_RST_OPEN_OVR  8'h40
`define DFEMR_RST_TIMER     8'h30
`define DFEMR_RST_MERIT     7'h72
`define DFEMR_RST_WORD      16'h0000
`define DFEMR_RST_VRSV      5'h00

`define DFEMR_B_EQ_DIS      3
`define DFEMR_B_FAST        7
`define DFEMR_B_NOLOCK      6
`define DFEMR_B_NOHIT       5
`define DFEMR_B_NOVERT      4
`define DFEMR_B_RSV3        3
`define DFEMR_B_ADAPT       2
`define DFEMR_B_MEAS        1
`define DFEMR_B_COUNT       0
`define DFEMR_B_OVR7        7
`define DFEMR_B_OVR6        6
`define DFEMR_B_SCALE       6
`define DFEMR_B_RSV7        7

`define DFEMR_HOPEN_MAX     8'h3f
`define DFEMR_MERIT_BAD     2'h0
`define DFEMR_N_START       3

`define DFEMR_F_TAP5        15:12
`define DFEMR_F_TAP4        11:8
`define DFEMR_F_TAP3        7:4
`define DFEMR_F_TAP2        3:0
`define DFEMR_F_VLEVEL      5:0
`define DFEMR_F_MINHIT      3:0
`define DFEMR_F_MERIT       5:4
`define DFEMR_F_LOOK        3:0
`define DFEMR_F_VRSV        4:0
`define DFEMR_F_MCFG        6:0

`endif

// ===== dfemr_start_bit.v
// Purpose: one self-clearing start bit with launch pulse
// Assumes: done comes from the engine on sys_clk
// Notes:   a write while busy does not relaunch unless done arrives in the same cycle
`timescale 1ns/1ns
`default_nettype none
module dfemr_start_bit (
   input  wire sys_clk,
   input  wire resetn,
   input  wire set_req,
   input  wire done,
   output wire launch,
   output reg  busy_r
);
   reg busy_nxt;

   assign launch = set_req & (~busy_r | done);

   always @* begin
      busy_nxt = busy_r;
      if (done)
         busy_nxt = 1'b0;
      // a new launch in the done cycle wins over the clear
      if (launch)
         busy_nxt = 1'b1;
   end

   always @(posedge sys_clk) begin
      if (!resetn)
         busy_r <= 1'b0;
      else
         busy_r <= busy_nxt;
   end
endmodule
`default_nettype wire

// ===== dfemr_vscale.v
// Purpose: scales a raw vertical opening by the monitor voltage range
// Assumes: range code n means full scale doubled n times
// Notes:   saturates at 8'hff rather than wrapping
`timescale 1ns/1ns
`default_nettype none
module dfemr_vscale (
   input  wire [7:0] raw,
   input  wire [1:0] vrange,
   input  wire       enable,
   output reg  [7:0] scaled
);
   reg [10:0] wide;

   always @* begin
      wide = {3'h0, raw} << vrange;
      if (!enable)
         scaled = raw;
      else if (wide[10:8] != 3'h0)
         scaled = 8'hff;
      else
         scaled = wide[7:0];
   end
endmodule
`default_nettype wire

// ===== dfemr_bank.v
// Functional notes
// - offset eq_tap5_tap4_weight holds tap 5 weight high nibble, tap 4 low; used under manual override
// - offset eq_tap3_tap2_weight holds tap 3 high nibble, tap 2 low; zero at reset
// - bit 7 of opening_override_eye_threshold_level gives software direct control of opening measurement
// - bit 7 of adapt_measure_start_status selects fast eye monitor mode; zero at reset
// - bit 5 of adapt_measure_start_status reads one when measurement found no crossing hits
// - bit 4 of adapt_measure_start_status reads one when no vertical opening was seen
// - writing one to bit 2 of adapt_measure_start_status starts adaptation; self-clearing
// - writing one to bit 1 of adapt_measure_start_status starts opening measurement; self-clearing
// - writing one to bit 0 of adapt_measure_start_status starts monitor counter; self-clearing
// - 16-bit monitor count read at eye_count_high high, eye_count_low low; zero at reset
// - horizontal_opening_value reads horizontal opening in phase steps 0 to 63
// - bits 6:5 of eye_voltage_range_view mirror the external monitor voltage range
// - eye_timer_threshold holds the monitor timer threshold, reset 8'h30
// - bits 3:0 of opening_min_hits are the minimum hit count for measurement
// - bit 6 of adapt_merit_config, set at reset, scales vertical opening by range
// - bits 5:4 of adapt_merit_config pick quality measure; 00 invalid, default 11
// - bits 3:0 of adapt_merit_config give settings tried past best; reset 2
// - bit 3 of 0x1e disables the equalizer when one; zero at reset
//
// Purpose: control/status bank of one retimer channel's equalizer and eye monitor
// Assumes: engines and register port run on sys_clk; reg_rdata_r valid cycle after reg_rd
// Notes:   unmapped offsets read zero and ignore writes
`timescale 1ns/1ns
`default_nettype none
`include "dfemr_regs.vh"
module dfemr_bank (
   input  wire        sys_clk,
   input  wire        resetn,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata_r,
   input  wire        eq_manual_override,
   input  wire [1:0]  eye_vrange,
   input  wire        adapt_done,
   input  wire        adapt_no_lock,
   input  wire        meas_done,
   input  wire [7:0]  meas_horizontal_opening,
   input  wire [7:0]  meas_vertical_opening,
   input  wire        meas_no_hits,
   input  wire        meas_no_vertical,
   input  wire        count_done,
   input  wire [15:0] count_value,
   output wire        adapt_start,
   output wire        meas_start,
   output wire        count_start,
   output wire [3:0]  eq_tap5_weight,
   output wire [3:0]  eq_tap4_weight,
   output wire [3:0]  eq_tap3_weight,
   output wire [3:0]  eq_tap2_weight,
   output wire        eq_disable,
   output wire        eye_monitor_override,
   output wire        opening_sw_control,
   output wire        feedback_equalizer_override,
   output wire [5:0]  eye_threshold_level,
   output wire        fast_monitor_mode,
   output wire [7:0]  eye_timer_threshold,
   output wire [3:0]  opening_min_hits,
   output wire        vertical_scale_en,
   output wire [1:0]  adaptation_quality_measure,
   output wire [3:0]  adapt_look_beyond
);
   reg  [7:0]  eq_dis_r;
   reg  [7:0]  tap54_r;
   reg  [7:0]  tap32_r;
   reg  [7:0]  mon_ovr_r;
   reg  [7:0]  open_ovr_r;
   reg         fast_r;
   reg         rsv3_r;
   reg         no_lock_r;
   reg         no_hit_r;
   reg         no_vert_r;
   reg  [15:0] count_r;
   reg  [7:0]  hopen_r;
   reg  [7:0]  vopen_r;
   reg         vr_rsv7_r;
   reg  [4:0]  vr_rsv_r;
   reg  [7:0]  timer_r;
   reg  [7:0]  minhit_r;
   reg         merit_rsv7_r;
   reg  [6:0]  merit_r;
   reg  [7:0]  rd_nxt;
   reg  [15:0] taps_r;
   reg  [15:0] taps_nxt;
   wire [7:0]  vopen_scaled;
   wire        wr_start;
   wire        adapt_ok;

   wire [`DFEMR_N_START-1:0] sc_req;
   wire [`DFEMR_N_START-1:0] sc_done;
   wire [`DFEMR_N_START-1:0] sc_launch;
   wire [`DFEMR_N_START-1:0] sc_busy;

   assign wr_start = reg_wr & (reg_addr == `DFEMR_A_START);
   // invalid quality code or disabled equalizer refuses an adaptation start
   assign adapt_ok = (merit_r[`DFEMR_F_MERIT] != `DFEMR_MERIT_BAD) &
                     ~eq_dis_r[`DFEMR_B_EQ_DIS];

   assign sc_req[`DFEMR_B_ADAPT] = wr_start & reg_wdata[`DFEMR_B_ADAPT] & adapt_ok;
   assign sc_req[`DFEMR_B_MEAS]  = wr_start & reg_wdata[`DFEMR_B_MEAS];
   assign sc_req[`DFEMR_B_COUNT] = wr_start & reg_wdata[`DFEMR_B_COUNT];
   assign sc_done[`DFEMR_B_ADAPT] = adapt_done;
   assign sc_done[`DFEMR_B_MEAS]  = meas_done;
   assign sc_done[`DFEMR_B_COUNT] = count_done;

   // bits stay set until their engine reports done, so software can poll
   genvar gi;
   generate
      for (gi = 0; gi < `DFEMR_N_START; gi = gi + 1) begin : g_start
         dfemr_start_bit u_sc (
            .sys_clk (sys_clk),
            .resetn  (resetn),
            .set_req (sc_req[gi]),
            .done    (sc_done[gi]),
            .launch  (sc_launch[gi]),
            .busy_r  (sc_busy[gi])
         );
      end
   endgenerate

   assign adapt_start = sc_launch[`DFEMR_B_ADAPT];
   assign meas_start  = sc_launch[`DFEMR_B_MEAS];
   assign count_start = sc_launch[`DFEMR_B_COUNT];

   dfemr_vscale u_vscale (
      .raw    (meas_vertical_opening),
      .vrange (eye_vrange),
      .enable (merit_r[`DFEMR_B_SCALE]),
      .scaled (vopen_scaled)
   );

   // weights reach the equalizer only under manual override and while enabled
   always @* begin
      taps_nxt = {tap54_r, tap32_r};
      if (~eq_manual_override | eq_dis_r[`DFEMR_B_EQ_DIS])
         taps_nxt = `DFEMR_RST_WORD;
   end

   // registered so the equalizer never sees a decode glitch; costs one cycle
   always @(posedge sys_clk) begin
      if (!resetn)
         taps_r <= `DFEMR_RST_WORD;
      else
         taps_r <= taps_nxt;
   end

   assign eq_tap5_weight              = taps_r[`DFEMR_F_TAP5];
   assign eq_tap4_weight              = taps_r[`DFEMR_F_TAP4];
   assign eq_tap3_weight              = taps_r[`DFEMR_F_TAP3];
   assign eq_tap2_weight              = taps_r[`DFEMR_F_TAP2];
   assign eq_disable                  = eq_dis_r[`DFEMR_B_EQ_DIS];
   assign eye_monitor_override        = mon_ovr_r[`DFEMR_B_OVR7];
   assign opening_sw_control          = open_ovr_r[`DFEMR_B_OVR7];
   assign feedback_equalizer_override = open_ovr_r[`DFEMR_B_OVR6];
   assign eye_threshold_level         = open_ovr_r[`DFEMR_F_VLEVEL];
   assign fast_monitor_mode           = fast_r;
   assign eye_timer_threshold         = timer_r;
   assign opening_min_hits            = minhit_r[`DFEMR_F_MINHIT];
   assign vertical_scale_en           = merit_r[`DFEMR_B_SCALE];
   assign adaptation_quality_measure  = merit_r[`DFEMR_F_MERIT];
   assign adapt_look_beyond           = merit_r[`DFEMR_F_LOOK];

   // software writes
   always @(posedge sys_clk) begin
      if (!resetn) begin
         eq_dis_r     <= `DFEMR_RST_ZERO;
         tap54_r      <= `DFEMR_RST_ZERO;
         tap32_r      <= `DFEMR_RST_ZERO;
         mon_ovr_r    <= `DFEMR_RST_ZERO;
         open_ovr_r   <= `DFEMR_RST_OPEN_OVR;
         fast_r       <= 1'b0;
         rsv3_r       <= 1'b0;
         vr_rsv7_r    <= 1'b0;
         vr_rsv_r     <= `DFEMR_RST_VRSV;
         timer_r      <= `DFEMR_RST_TIMER;
         minhit_r     <= `DFEMR_RST_ZERO;
         merit_rsv7_r <= 1'b0;
         merit_r      <= `DFEMR_RST_MERIT;
      end else if (reg_wr) begin
         case (reg_addr)
            `DFEMR_A_EQ_DIS: begin
               eq_dis_r <= reg_wdata;
            end
            `DFEMR_A_TAP54: begin
               tap54_r <= reg_wdata;
            end
            `DFEMR_A_TAP32: begin
               tap32_r <= reg_wdata;
            end
            `DFEMR_A_MON_OVR: begin
               mon_ovr_r <= reg_wdata;
            end
            `DFEMR_A_OPEN_OVR: begin
               open_ovr_r <= reg_wdata;
            end
            `DFEMR_A_START: begin
               fast_r <= reg_wdata[`DFEMR_B_FAST];
               rsv3_r <= reg_wdata[`DFEMR_B_RSV3];
            end
            `DFEMR_A_VRANGE: begin
               vr_rsv7_r <= reg_wdata[`DFEMR_B_RSV7];
               vr_rsv_r  <= reg_wdata[`DFEMR_F_VRSV];
            end
            `DFEMR_A_TIMER: begin
               timer_r <= reg_wdata;
            end
            `DFEMR_A_MINHIT: begin
               minhit_r <= reg_wdata;
            end
            `DFEMR_A_MERIT: begin
               merit_rsv7_r <= reg_wdata[`DFEMR_B_RSV7];
               merit_r      <= reg_wdata[`DFEMR_F_MCFG];
            end
            default: begin
               eq_dis_r <= eq_dis_r;
            end
         endcase
      end
   end

   // engine results; flags are refreshed by each completion, not by software
   always @(posedge sys_clk) begin
      if (!resetn) begin
         no_lock_r <= 1'b0;
         no_hit_r  <= 1'b0;
         no_vert_r <= 1'b0;
         count_r   <= `DFEMR_RST_WORD;
         hopen_r   <= `DFEMR_RST_ZERO;
         vopen_r   <= `DFEMR_RST_ZERO;
      end else begin
         if (adapt_done)
            no_lock_r <= adapt_no_lock;
         if (meas_done) begin
            no_hit_r  <= meas_no_hits;
            no_vert_r <= meas_no_vertical;
            vopen_r   <= vopen_scaled;
            // phase steps top out at 63; a larger report is clipped
            if (meas_horizontal_opening > `DFEMR_HOPEN_MAX)
               hopen_r <= `DFEMR_HOPEN_MAX;
            else
               hopen_r <= meas_horizontal_opening;
         end
         if (count_done)
            count_r <= count_value;
      end
   end

   // read mux; no read side effects, so the two count bytes may tear if a count completes between the two reads
   always @* begin
      case (reg_addr)
         `DFEMR_A_EQ_DIS: begin
            rd_nxt = eq_dis_r;
         end
         `DFEMR_A_TAP54: begin
            rd_nxt = tap54_r;
         end
         `DFEMR_A_TAP32: begin
            rd_nxt = tap32_r;
         end
         `DFEMR_A_MON_OVR: begin
            rd_nxt = mon_ovr_r;
         end
         `DFEMR_A_OPEN_OVR: begin
            rd_nxt = open_ovr_r;
         end
         `DFEMR_A_START: begin
            rd_nxt = {fast_r, no_lock_r, no_hit_r, no_vert_r,
                      rsv3_r, sc_busy[`DFEMR_B_ADAPT],
                      sc_busy[`DFEMR_B_MEAS],
                      sc_busy[`DFEMR_B_COUNT]};
         end
         `DFEMR_A_CNT_HI: begin
            rd_nxt = count_r[15:8];
         end
         `DFEMR_A_CNT_LO: begin
            rd_nxt = count_r[7:0];
         end
         `DFEMR_A_HOPEN: begin
            rd_nxt = hopen_r;
         end
         `DFEMR_A_VOPEN: begin
            rd_nxt = vopen_r;
         end
         `DFEMR_A_VRANGE: begin
            rd_nxt = {vr_rsv7_r, eye_vrange, vr_rsv_r};
         end
         `DFEMR_A_TIMER: begin
            rd_nxt = timer_r;
         end
         `DFEMR_A_MINHIT: begin
            rd_nxt = minhit_r;
         end
         `DFEMR_A_MERIT: begin
            rd_nxt = {merit_rsv7_r, merit_r};
         end
         default: begin
            rd_nxt = `DFEMR_RST_ZERO;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (!resetn)
         reg_rdata_r <= `DFEMR_RST_ZERO;
      else if (reg_rd)
         reg_rdata_r <= rd_nxt;
   end
endmodule
`default_nettype wire

// ===== dfemr_bank_sva.sv
// Purpose: port-level assertions for dfemr_bank
// Assumes: one sys_clk domain, synchronous active-low reset
// Notes:   bound into every dfemr_bank instance
`timescale 1ns/1ns
`default_nettype none
module dfemr_bank_sva (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata_r,
   input wire logic        eq_manual_override,
   input wire logic [1:0]  eye_vrange,
   input wire logic        meas_done,
   input wire logic [7:0]  meas_horizontal_opening,
   input wire logic        count_done,
   input wire logic [15:0] count_value,
   input wire logic        adapt_start,
   input wire logic        meas_start,
   input wire logic        count_start,
   input wire logic [3:0]  eq_tap3_weight,
   input wire logic [3:0]  eq_tap2_weight,
   input wire logic        eq_disable,
   input wire logic        fast_monitor_mode,
   input wire logic [7:0]  eye_timer_threshold,
   input wire logic        vertical_scale_en,
   input wire logic [1:0]  adaptation_quality_measure,
   input wire logic [3:0]  adapt_look_beyond
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   wire logic w24 = reg_wr && reg_addr == 8'h24;
   // a read is only checked when no new capture lands on the same edge
   sequence tap_wr;
      reg_wr && reg_addr == 8'h21 ##1 eq_manual_override && !eq_disable ##1 1'b1;
   endsequence
   sequence cnt_rd;
      count_done ##1 reg_rd && reg_addr == 8'h26 && !count_done;
   endsequence
   sequence hop_rd;
      meas_done ##1 reg_rd && reg_addr == 8'h27 && !meas_done;
   endsequence
   adapt_pulse_a: assert property (adapt_start |-> w24 && reg_wdata[2])
      else $error("adapt start without write");
   adapt_refuse_a: assert property (adapt_start |-> adaptation_quality_measure != 2'h0 && !eq_disable)
      else $error("adapt start not refused");
   meas_pulse_a: assert property (meas_start |-> w24 && reg_wdata[1])
      else $error("measure start without write");
   count_pulse_a: assert property (count_start |-> w24 && reg_wdata[0])
      else $error("count start without write");
   tap_gate_a: assert property (!$past(eq_manual_override) || $past(eq_disable) |->
      {eq_tap3_weight, eq_tap2_weight} == 8'h00)
      else $error("tap weights not gated");
   tap_load_a: assert property (tap_wr |-> {eq_tap3_weight, eq_tap2_weight} == $past(reg_wdata, 2))
      else $error("tap weights not loaded");
   timer_load_a: assert property (reg_wr && reg_addr == 8'h2a |=> eye_timer_threshold == $past(reg_wdata))
      else $error("timer threshold not loaded");
   merit_load_a: assert property (reg_wr && reg_addr == 8'h2c |=>
      {vertical_scale_en, adaptation_quality_measure, adapt_look_beyond} == $past(reg_wdata[6:0]))
      else $error("merit config not loaded");
   fast_load_a: assert property (w24 |=> fast_monitor_mode == $past(reg_wdata[7]))
      else $error("fast mode not loaded");
   range_view_a: assert property (reg_rd && reg_addr == 8'h29 |=> reg_rdata_r[6:5] == $past(eye_vrange))
      else $error("range view wrong");
   count_low_a: assert property (cnt_rd |=> reg_rdata_r == $past(count_value[7:0], 2))
      else $error("count low byte wrong");
   hop_clip_a: assert property (hop_rd |=> reg_rdata_r ==
      ($past(meas_horizontal_opening, 2) > 8'h3f ? 8'h3f : $past(meas_horizontal_opening, 2)))
      else $error("horizontal opening wrong");
endmodule
bind dfemr_bank dfemr_bank_sva i_sva (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata_r, .eq_manual_override, .eye_vrange, .meas_done, .meas_horizontal_opening,
   .count_done, .count_value, .adapt_start, .meas_start, .count_start, .eq_tap3_weight,
   .eq_tap2_weight, .eq_disable, .fast_monitor_mode, .eye_timer_threshold, .vertical_scale_en,
   .adaptation_quality_measure, .adapt_look_beyond);
`default_nettype wire

// ===== dfemr_bank_test.sv
// Purpose: self-checking bench for dfemr_bank
// Assumes: inputs change on the falling edge
// Notes:   bench pulses stand in for the engines
`timescale 1ns/1ns
`default_nettype none
module dfemr_bank_test;
   reg         sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   reg         eq_manual_override = 1'b0, adapt_done = 1'b0, adapt_no_lock = 1'b0;
   reg         meas_done = 1'b0, meas_no_hits = 1'b0, meas_no_vertical = 1'b0;
   reg         count_done = 1'b0, dis = 1'b0, nl = 1'b0;
   reg  [1:0]  eye_vrange = 2'h0, fl = 2'h0;
   reg  [2:0]  st = 3'h0;
   reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, hop = 8'h00, vop = 8'h00, e, d;
   reg  [15:0] count_value = 16'h0000;
   wire [7:0]  reg_rdata_r;
   wire [3:0]  eq_tap5_weight, eq_tap4_weight;
   wire        adapt_start, meas_start, count_start;
   wire [7:0]  o23;
   wire [3:0]  mh;
   wire        mo;
   integer     seed = 7, num_errors = 0, comparisons = 0, cyc = 0, i, k;
   localparam [63:0] RWA = 64'h1e202122232a2b2c;
   dfemr_bank i_dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
      .eq_manual_override, .eye_vrange, .adapt_done, .adapt_no_lock, .meas_done,
      .meas_horizontal_opening(hop), .meas_vertical_opening(vop), .meas_no_hits,
      .meas_no_vertical, .count_done, .count_value, .adapt_start, .meas_start, .count_start,
      .eq_tap5_weight, .eq_tap4_weight, .eq_tap3_weight(), .eq_tap2_weight(), .eq_disable(),
      .eye_monitor_override(mo), .opening_sw_control(o23[7]),
      .feedback_equalizer_override(o23[6]), .eye_threshold_level(o23[5:0]),
      .fast_monitor_mode(), .eye_timer_threshold(), .opening_min_hits(mh),
      .vertical_scale_en(), .adaptation_quality_measure(),
      .adapt_look_beyond());
   always #20 sys_clk = ~sys_clk;
   function [7:0] rstv(input [7:0] a);
      rstv = a == 8'h23 ? 8'h40 : a == 8'h2a ? 8'h30 : a == 8'h2c ? 8'h72 : 8'h00;
   endfunction
   function [7:0] vsc(input [7:0] raw, input [1:0] rng, input en);
      reg [10:0] t;
      begin
         t = {3'h0, raw} << rng;
         vsc = !en ? raw : (|t[10:8] ? 8'hff : t[7:0]);
      end
   endfunction
   task finish_test;
      begin
         $display("errors %0d comparisons %0d", num_errors, comparisons);
         if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // strobes stay up across back-to-back accesses; the other kind lowers them
   task wr(input [7:0] a, input [7:0] v);
      begin
         reg_rd = 1'b0;
         reg_addr = a;
         reg_wdata = v;
         reg_wr = 1'b1;
         #5 st = {adapt_start, meas_start, count_start};
         @(negedge sys_clk);
      end
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      begin
         reg_wr = 1'b0;
         reg_addr = a;
         reg_rd = 1'b1;
         @(negedge sys_clk);
         chk(reg_rdata_r, exp);
      end
   endtask
   task fin(input [2:0] w);
      begin
         reg_wr = 1'b0;
         reg_rd = 1'b0;
         {adapt_done, meas_done, count_done} = w;
         @(negedge sys_clk);
         {adapt_done, meas_done, count_done} = 3'h0;
      end
   endtask
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc > 5000) begin
         num_errors = num_errors + 1;
         $display("mismatch at %0t: timeout", $time);
         finish_test;
      end
   end
   initial begin
      repeat (3) @(negedge sys_clk);
      resetn = 1'b1;
      for (i = 8'h1e; i < 8'h2e; i = i + 1)
         rd(i[7:0], rstv(i[7:0]));
      for (k = 0; k < 24; k = k + 1) begin
         e = RWA[(7 - k % 8) * 8 +: 8];
         d = $random(seed);
         eq_manual_override = $random(seed);
         if (e == 8'h1e)
            dis = d[3];
         wr(e, d);
         rd(e, d);
         if (e == 8'h20)
            chk({eq_tap5_weight, eq_tap4_weight}, eq_manual_override && !dis ? d : 8'h00);
         if (e == 8'h22)
            chk({7'h00, mo}, {7'h00, d[7]});
         if (e == 8'h23)
            chk(o23, d);
         if (e == 8'h2b)
            chk({4'h0, mh}, {4'h0, d[3:0]});
      end
      for (k = 0; k < 2; k = k + 1) begin
         wr(k ? 8'h1f : 8'h2d, 8'hff);
         rd(k ? 8'h1f : 8'h2d, 8'h00);
      end
      wr(8'h1e, 8'h00);
      eye_vrange = $random(seed);
      d = $random(seed);
      wr(8'h29, d);
      rd(8'h29, {d[7], eye_vrange, d[4:0]});
      for (k = 0; k < 6; k = k + 1) begin
         eye_vrange = k == 1 ? 2'h3 : $random(seed);
         wr(8'h2c, {1'b0, k[0], 6'h32});
         wr(8'h24, {k[1], 7'h02});
         chk(st, 3'b010);
         rd(8'h24, {k[1], nl, fl, 4'h2});
         hop = k == 0 ? 8'hff : k == 2 ? 8'h3f : $random(seed);
         vop = k == 1 ? 8'h81 : $random(seed);
         {meas_no_hits, meas_no_vertical} = $random(seed);
         fl = {meas_no_hits, meas_no_vertical};
         fin(3'b010);
         rd(8'h27, hop > 8'h3f ? 8'h3f : hop);
         rd(8'h28, vsc(vop, eye_vrange, k[0]));
         rd(8'h24, {k[1], nl, fl, 4'h0});
      end
      // done and a new start in one cycle: the start wins and relaunches
      wr(8'h24, 8'h02);
      meas_done = 1'b1;
      wr(8'h24, 8'h02);
      chk(st, 3'b010);
      meas_done = 1'b0;
      rd(8'h24, {2'b00, fl, 4'h2});
      fin(3'b010);
      wr(8'h24, 8'h04);
      chk(st, 3'b100);
      wr(8'h24, 8'h04);
      chk(st, 3'b000);
      adapt_no_lock = 1'b1;
      nl = 1'b1;
      fin(3'b100);
      rd(8'h24, {2'b01, fl, 4'h0});
      for (k = 0; k < 2; k = k + 1) begin
         wr(8'h2c, k ? 8'h72 : 8'h42);
         wr(8'h1e, k ? 8'h08 : 8'h00);
         wr(8'h24, 8'h04);
         chk(st, 3'b000);
         rd(8'h24, {2'b01, fl, 4'h0});
      end
      eq_manual_override = 1'b1;
      wr(8'h20, 8'ha5);
      chk({eq_tap5_weight, eq_tap4_weight}, 8'h00);
      wr(8'h1e, 8'h00);
      count_value = $random(seed);
      wr(8'h24, 8'h01);
      chk(st, 3'b001);
      chk({eq_tap5_weight, eq_tap4_weight}, 8'ha5);
      fin(3'b001);
      rd(8'h26, count_value[7:0]);
      rd(8'h25, count_value[15:8]);
      rd(8'h24, {2'b01, fl, 4'h0});
      finish_test;
   end
endmodule
`default_nettype wire
